//--- verilog/hbf_core.sv
`timescale 1ns/1ps
`default_nettype none
module hbf_core
   import hbf_pkg::*;
#(
   parameter int OC_CYC = hbf_pkg::OC_FILTER_CYC,
   parameter int UL_CYC = hbf_pkg::UL_DELAY_CYC,
   parameter int SR_CYC = hbf_pkg::CLR_HOLD_CYC
) (
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic                       linkClk,
   input  wire logic                       selectLow,
   input  wire logic                       serialIn,
   output logic                            serialOut,
   output logic                            serialOutOe,
   input  wire logic                       enablePin,
   input  wire logic [1:0]                 supplyUnder,
   input  wire logic [1:0]                 supplyOver,
   input  wire logic [hbf_pkg::NUM_CH-1:0] ocHigh,
   input  wire logic [hbf_pkg::NUM_CH-1:0] ocLow,
   input  wire logic [hbf_pkg::NUM_CH-1:0] underload,
   input  wire logic [hbf_pkg::NUM_CH-1:0] thermWarn,
   input  wire logic [hbf_pkg::NUM_CH-1:0] thermShut,
   output logic      [hbf_pkg::NUM_CH-1:0] highSideOn,
   output logic      [hbf_pkg::NUM_CH-1:0] lowSideOn,
   output logic      [2*hbf_pkg::NUM_CH-1:0] channelOutputStatus,
   output logic                            supplyFailFlag,
   output logic                            overcurrentFlag,
   output logic                            underloadFlag,
   output logic                            thermalWarningFlag,
   output logic                            thermalShutdownFlag,
   output logic                            clearHoldoff
);
   import hbf_pkg::*;

   localparam int OCW = $clog2(OC_CYC + 1);
   localparam int ULW = $clog2(UL_CYC + 1);
   localparam int SRW = $clog2(SR_CYC + 1);
   localparam int SW  = 2 + 2 + 2 + 5 * NUM_CH + 1;

   // ************************************************************
   // link domain: shift registers on the serial clock
   // ************************************************************
   typedef struct packed {
      logic [CMD_BITS-1:0] rx;
      logic [ST_BITS-1:0]  tx;
      logic [CMD_BITS-1:0] cmdHold;
      logic                cmdTog;
   } hbf_link_t;

   hbf_link_t           lq;
   hbf_link_t           ld;
   logic [BITCNT_W-1:0] bitCnt_q;
   logic [BITCNT_W-1:0] bitCnt_d;

   typedef struct packed {
      hbf_frame_t                     frame;
      logic                           togSeen;
      logic [CMD_BITS-1:0]            cfg;
      logic [NUM_CH-1:0]              ocLatch;
      logic [NUM_CH-1:0]              ulLatch;
      logic [NUM_CH-1:0]              tsdLatch;
      logic [NUM_CH-1:0]              hsOn;
      logic [NUM_CH-1:0]              lsOn;
      logic [NUM_CH-1:0][OCW-1:0]     ocCnt;
      logic [ULW-1:0]                 ulCnt;
      logic [SRW-1:0]                 holdCnt;
      logic [ST_BITS-1:0]             live;
      logic [ST_BITS-1:0]             snap;
      logic                           tsdSnap;
      logic                           busy;
   } hbf_state_t;

   hbf_state_t q;
   hbf_state_t d;

   // bit counter restarts whenever select is released; the words
   // below are cleared by rst, not by select or the counter
   always_comb begin
      ld = lq;
      bitCnt_d = bitCnt_q;
      if (bitCnt_q != BITCNT_W'(CMD_BITS)) begin
         bitCnt_d = bitCnt_q + BITCNT_W'(1);
      end
      ld.rx = {lq.rx[CMD_BITS-2:0], serialIn};
      if (bitCnt_q == '0) begin
         ld.tx = q.snap;
      end else begin
         ld.tx = {lq.tx[ST_BITS-2:0], 1'b0};
      end
      // word held until next full frame, so the main side may read it
      if (bitCnt_q == BITCNT_W'(CMD_BITS - 1)) begin
         ld.cmdHold = ld.rx;
         ld.cmdTog  = ~lq.cmdTog;
      end
   end

   always_ff @(posedge linkClk or posedge selectLow) begin
      if (selectLow) begin
         bitCnt_q <= '0;
      end else begin
         bitCnt_q <= bitCnt_d;
      end
   end

   // asynchronous reset, as the link clock may be idle, so the toggle starts known
   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         lq <= '0;
      end else begin
         lq <= ld;
      end
   end

   // pre-bit is combinational: it must appear before any clock edge
   // shutdown flag or input
   assign serialOut   = (bitCnt_q == '0) ? (q.tsdSnap | serialIn)
                                         : lq.tx[ST_BITS-1];
   assign serialOutOe = ~selectLow;

   // ************************************************************
   // main domain: synchronised pins and fault supervision
   // ************************************************************
   logic [SW-1:0]     syncBus;
   logic              selLowS;
   logic              enS;
   logic [1:0]        uvS;
   logic [1:0]        ovS;
   logic [NUM_CH-1:0] ocHS;
   logic [NUM_CH-1:0] ocLS;
   logic [NUM_CH-1:0] ulS;
   logic [NUM_CH-1:0] twS;
   logic [NUM_CH-1:0] tsdS;
   logic              togS;

   hbf_sync #(
      .WIDTH (SW)
   ) uSync (
      .clock   (clock),
      .rst     (rst),
      .asyncIn ({lq.cmdTog, thermShut, thermWarn, underload, ocLow,
                 ocHigh, supplyOver, supplyUnder, enablePin,
                 selectLow}),
      .syncOut (syncBus)
   );

   assign {togS, tsdS, twS, ulS, ocLS, ocHS, ovS, uvS, enS, selLowS} =
      syncBus;

   logic selRise;
   logic cmdNew;
   logic clrEvt;
   logic clearAll;
   logic uvAny;
   logic ovAny;
   logic lockout;
   logic ulDone;
   logic ulsdEn;
   logic ocAct;
   logic off;

   always_comb begin
      d = q;
      selRise  = (q.frame == FR_ACTIVE) && selLowS;
      cmdNew   = selRise && (togS != q.togSeen);
      clrEvt   = cmdNew && lq.cmdHold[CMD_CLRQ_BIT];
      clearAll = clrEvt || !enS;
      uvAny    = |uvS;
      ovAny    = |ovS;
      ulsdEn   = q.cfg[CMD_ULSD_BIT];
      ulDone   = (q.ulCnt == ULW'(UL_CYC));
      ocAct    = 1'b0;
      off      = 1'b0;

      case (q.frame)
         FR_IDLE: begin
            if (!selLowS) begin
               d.frame = FR_ACTIVE;
            end
         end
         FR_ACTIVE: begin
            if (selLowS) begin
               d.frame = FR_IDLE;
            end
         end
         default: begin
            d.frame = FR_IDLE;
         end
      endcase

      // commands taken in any supply state
      if (cmdNew) begin
         d.cfg     = lq.cmdHold;
         d.togSeen = togS;
      end

      lockout = uvAny || (ovAny && q.cfg[CMD_OVLK_BIT]);

      if (!(|ulS)) begin
         d.ulCnt = '0;
      end else if (!ulDone) begin
         d.ulCnt = q.ulCnt + ULW'(1);
      end

      // clear before sets so a live fault wins
      if (clearAll) begin
         d.ocLatch  = '0;
         d.ulLatch  = '0;
         d.tsdLatch = '0;
      end

      for (int i = 0; i < NUM_CH; i++) begin
         ocAct = ocHS[i] || ocLS[i];
         if (!ocAct || clearAll) begin
            d.ocCnt[i] = '0;
         end else if (q.ocCnt[i] != OCW'(OC_CYC)) begin
            d.ocCnt[i] = q.ocCnt[i] + OCW'(1);
         end
         if (ocAct && q.ocCnt[i] == OCW'(OC_CYC)) begin
            d.ocLatch[i] = 1'b1;
         end
         if (ulS[i] && ulDone) begin
            d.ulLatch[i] = 1'b1;
         end
         if (tsdS[i]) begin
            d.tsdLatch[i] = 1'b1;
         end
         // outputs follow command once lockout ends
         off = d.ocLatch[i] || d.tsdLatch[i] || !enS || lockout ||
               (d.ulLatch[i] && ulsdEn);
         d.hsOn[i] = q.cfg[CMD_EN_LSB + i] && q.cfg[CMD_SIDE_LSB + i]
                     && !off;
         d.lsOn[i] = q.cfg[CMD_EN_LSB + i] && !q.cfg[CMD_SIDE_LSB + i]
                     && !off;
         if (d.ocLatch[i]) begin
            d.live[ST_CH_LSB + 2*i +: 2] = HBS_OC;
         end else if (d.tsdLatch[i]) begin
            d.live[ST_CH_LSB + 2*i +: 2] = HBS_TSD;
         end else if (d.ulLatch[i]) begin
            d.live[ST_CH_LSB + 2*i +: 2] = HBS_UL;
         end else begin
            d.live[ST_CH_LSB + 2*i +: 2] = HBS_NONE;
         end
      end

      // flag set whatever the lockout bit
      d.live[ST_SUPPLY_BIT] = uvAny || ovAny;
      d.live[ST_OC_BIT]     = |d.ocLatch;
      d.live[ST_UL_BIT]     = |d.ulLatch;
      d.live[ST_WARN_BIT]   = |twS;

      if (clrEvt) begin
         d.holdCnt = SRW'(SR_CYC);
      end else if (q.holdCnt != '0) begin
         d.holdCnt = q.holdCnt - SRW'(1);
      end
      d.busy = (d.holdCnt != '0);

      // refresh only between frames, not during the hold-off after a reset request
      if (selLowS && q.frame == FR_IDLE && q.holdCnt == '0) begin
         d.snap    = q.live;
         d.tsdSnap = |q.tsdLatch;
      end

      if (rst) begin
         d         = '0;
         d.frame   = FR_IDLE;
         d.cfg     = CMD_RESET;
         d.live    = ST_RESET;
         d.snap    = ST_RESET;
         d.togSeen = togS;
      end
   end

   always_ff @(posedge clock) begin
      q <= d;
   end

   assign highSideOn          = q.hsOn;
   assign lowSideOn           = q.lsOn;
   assign channelOutputStatus = q.live[ST_CH_LSB +: 2*NUM_CH];
   assign supplyFailFlag      = q.live[ST_SUPPLY_BIT];
   assign overcurrentFlag     = q.live[ST_OC_BIT];
   assign underloadFlag       = q.live[ST_UL_BIT];
   assign thermalWarningFlag  = q.live[ST_WARN_BIT];
   assign thermalShutdownFlag = q.tsdSnap;
   assign clearHoldoff        = q.busy;

   // ************************************************************
   // checks
   // ************************************************************
   a_clr_clears_tsd: assert property (
      @(posedge clock) disable iff (rst)
      clrEvt && !tsdS[0] |=> !q.tsdLatch[0])
      else $error("reset request left shutdown latched");

   a_clr_holdoff_run: assert property (
      @(posedge clock) disable iff (rst)
      clrEvt |=> clearHoldoff [*8])
      else $error("hold-off did not start on reset request");

   a_snap_frozen: assert property (
      @(posedge clock) disable iff (rst)
      !selLowS && q.frame == FR_ACTIVE |=> $stable(q.snap))
      else $error("status snapshot changed inside a frame");

   a_uv_outputs_off: assert property (
      @(posedge clock) disable iff (rst)
      uvAny |=> (q.hsOn == '0) && (q.lsOn == '0) && supplyFailFlag)
      else $error("outputs on during undervoltage");

   a_ov_flag_only: assert property (
      @(posedge clock) disable iff (rst)
      ovAny && !q.cfg[CMD_OVLK_BIT] |=> supplyFailFlag)
      else $error("supply-fail missing during overvoltage");

   a_oc_filter_latch: assert property (
      @(posedge clock) disable iff (rst)
      (ocHS[0] || ocLS[0]) && q.ocCnt[0] == OCW'(OC_CYC) |=>
         q.ocLatch[0] && !q.hsOn[0] && !q.lsOn[0] && overcurrentFlag)
      else $error("overcurrent not latched after filter");

   a_oc_code_wins: assert property (
      @(posedge clock) disable iff (rst)
      q.ocLatch[0] |-> channelOutputStatus[1:0] == HBS_OC)
      else $error("overcurrent code not reported first");

   a_en_low_clears: assert property (
      @(posedge clock) disable iff (rst)
      !enS ##1 !enS && !(|ocHS) && !(|ocLS) && !(|ulS) && !(|tsdS)
         |=> q.ocLatch == '0 && q.ulLatch == '0 && q.tsdLatch == '0)
      else $error("enable low did not clear status");

   a_tsd_latch_off: assert property (
      @(posedge clock) disable iff (rst)
      tsdS[0] |=> q.tsdLatch[0] && !q.hsOn[0] && !q.lsOn[0])
      else $error("shutdown did not latch channel off");

   a_ul_no_shut: assert property (
      @(posedge clock) disable iff (rst)
      ulS[0] && ulDone && !ulsdEn |=> q.ulLatch[0] && underloadFlag)
      else $error("underload not latched with shutdown disabled");
endmodule
`default_nettype wire

//--- inc/hbf_pkg.sv
// ************************************************************
// shared constants for the half-bridge fault block
// ************************************************************
package hbf_pkg;
   localparam int NUM_CH        = 6;
   localparam int CMD_BITS      = 16;
   localparam int ST_BITS       = 16;
   localparam int BITCNT_W      = 5;

   // ************************************************************
   // command word fields
   // ************************************************************
   localparam int CMD_EN_LSB    = 0;
   localparam int CMD_SIDE_LSB  = 6;
   localparam int CMD_ULSD_BIT  = 12;
   localparam int CMD_OVLK_BIT  = 13;
   localparam int CMD_CLRQ_BIT  = 15;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // ************************************************************
   // status word fields and channel codes
   // ************************************************************
   localparam int ST_CH_LSB     = 0;
   localparam int ST_SUPPLY_BIT = 12;
   localparam int ST_OC_BIT     = 13;
   localparam int ST_UL_BIT     = 14;
   localparam int ST_WARN_BIT   = 15;
   localparam logic [15:0] ST_RESET = 16'h0000;
   localparam logic [1:0] HBS_NONE = 2'h0;
   localparam logic [1:0] HBS_OC   = 2'h1;
   localparam logic [1:0] HBS_UL   = 2'h2;
   localparam logic [1:0] HBS_TSD  = 2'h3;

   // ************************************************************
   // timing, least times round up
   // ************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int OC_FILTER_NS  = 10000;
   localparam int UL_DELAY_NS   = 200000;
   localparam int CLR_HOLD_NS   = 100000;
   localparam int OC_FILTER_CYC =
      (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UL_DELAY_CYC  =
      (UL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLR_HOLD_CYC  =
      (CLR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic {FR_IDLE, FR_ACTIVE} hbf_frame_t;
endpackage

//--- verilog/hbf_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// two-stage synchroniser, first stage feeds only the second
// ************************************************************
module hbf_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } hbf_sync_t;

   hbf_sync_t q;
   hbf_sync_t d;

   always_comb begin
      d.meta   = asyncIn;
      d.stable = q.meta;
      if (rst) begin
         d = '0;
      end
   end

   always_ff @(posedge clock) begin
      q <= d;
   end

   assign syncOut = q.stable;
endmodule
`default_nettype wire

//--- tb/hbf_host.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// serial host model, link clock 80 ns, idle low between frames
// ************************************************************
module hbf_host (
   output logic      linkClk,
   output logic      selectLow,
   output logic      serialIn,
   input  wire logic serialOut
);
   logic [15:0] lastCmd;

   initial begin
      linkClk = 1'b0;
      selectLow = 1'b1;
      serialIn = 1'b0;
      lastCmd = 16'h0000;
   end

   // clock and data low before select
   task automatic frame(input logic [15:0] c, output logic [15:0] st,
                        output logic pre);
      integer i;
      linkClk = 1'b0;
      serialIn = 1'b0;
      #10 selectLow = 1'b0;
      #80 pre = serialOut;
      for (i = 15; i >= 0; i--) begin
         serialIn = c[i];
         #40 linkClk = 1'b1;
         #40 st[i] = serialOut;
         linkClk = 1'b0;
      end
      // pulled-down input goes low once released
      #40 selectLow = 1'b1;
      serialIn = 1'b0;
      // keep the last word, with its clear-request bit 15 dropped, for status reads
      lastCmd = c & 16'h7FFF;
      #160;
   endtask

   // status read resends the previous word
   task automatic poll(output logic [15:0] st, output logic pre);
      frame(lastCmd, st, pre);
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hbf_pkg::*;
   localparam int OCC = 8;
   localparam int ULC = 20;
   localparam int SRC = 16;
   logic              clock, rst, linkClk, selectLow, serialIn;
   logic              serialOut, serialOutOe, enablePin;
   logic [1:0]        supplyUnder, supplyOver;
   logic [NUM_CH-1:0] ocHigh, ocLow, underload, thermWarn, thermShut;
   logic [NUM_CH-1:0] highSideOn, lowSideOn;
   logic [11:0]       chSt;
   logic              supFail, ocFlag, ulFlag, twFlag, tsdFlag, hold;
   logic [15:0]       cmd, st;
   logic              pre;
   int                err_total, compares, a, b, n;

   hbf_core #(.OC_CYC(OCC), .UL_CYC(ULC), .SR_CYC(SRC)) uut (
      .clock(clock), .rst(rst), .linkClk(linkClk),
      .selectLow(selectLow), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutOe(serialOutOe),
      .enablePin(enablePin), .supplyUnder(supplyUnder),
      .supplyOver(supplyOver), .ocHigh(ocHigh), .ocLow(ocLow),
      .underload(underload), .thermWarn(thermWarn),
      .thermShut(thermShut), .highSideOn(highSideOn),
      .lowSideOn(lowSideOn), .channelOutputStatus(chSt),
      .supplyFailFlag(supFail), .overcurrentFlag(ocFlag),
      .underloadFlag(ulFlag), .thermalWarningFlag(twFlag),
      .thermalShutdownFlag(tsdFlag), .clearHoldoff(hold));
   hbf_host host (.linkClk(linkClk), .selectLow(selectLow),
      .serialIn(serialIn), .serialOut(serialOut));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   function automatic logic [15:0] expDrv(logic [15:0] c, logic [5:0] off);
      return {4'h0, c[5:0] & c[11:6] & ~off, c[5:0] & ~c[11:6] & ~off};
   endfunction

   task automatic print_verdict();
      if (err_total == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chkV(logic [15:0] got, logic [15:0] exp, string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %0t %s %h %h", $time, m, got, exp);
      end
   endtask

   task automatic chkB(logic got, logic exp, string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge clock);
      #2;
   endtask

   task automatic outs(logic [5:0] off);
      chkV({4'h0, highSideOn, lowSideOn}, expDrv(cmd, off), "drivers");
   endtask

   task automatic code(int ch, logic [1:0] e);
      chkV({14'h0, chSt[2*ch+:2]}, {14'h0, e}, "channel code");
   endtask

   task automatic send(logic [15:0] c);
      cmd = c;
      host.frame(c, st, pre);
      tick(8);
   endtask

   task automatic clearReq();
      host.frame(cmd | 16'h8000, st, pre);
      tick(6);
      chkB(hold, 1'b1, "hold-off start");
      for (n = 0; n < SRC + 10 && hold; n++)
         tick(1);
      chkB(hold, 1'b0, "hold-off end");
   endtask

   initial begin
      #1000000;
      err_total++;
      print_verdict();
   end

   initial begin
      err_total = 0;
      compares = 0;
      rst = 1'b1;
      enablePin = 1'b1;
      {supplyUnder, supplyOver} = 4'h0;
      {ocHigh, ocLow, underload, thermWarn, thermShut} = '0;
      a = $urandom(32'hA7F8);
      cmd = 16'h0000;
      tick(12);
      rst = 1'b0;
      tick(1);
      outs(6'h3F);
      repeat (4) begin
         send(16'h3000 | 16'($urandom & 32'hFFF));
         outs(6'h00);
         host.poll(st, pre);
         tick(8);
         outs(6'h00);
      end
      // supply undervoltage keeps the link alive
      supplyUnder = 2'($urandom_range(1, 3));
      tick(6);
      outs(6'h3F);
      chkB(supFail, 1'b1, "uv flag");
      send(16'h3000 | 16'($urandom & 32'hFFF));
      chkV({4'h0, highSideOn, lowSideOn}, 16'h0000, "uv writes");
      supplyUnder = 2'h0;
      tick(6);
      outs(6'h00);
      chkB(supFail, 1'b0, "uv clear");
      for (b = 1; b >= 0; b--) begin
         cmd[13] = b[0];
         send(cmd);
         supplyOver = 2'($urandom_range(1, 3));
         tick(6);
         chkB(supFail, 1'b1, "ov flag");
         outs(b ? 6'h3F : 6'h00);
         cmd[5:0] = 6'($urandom);
         send(cmd);
         if (b)
            outs(6'h3F);
         supplyOver = 2'h0;
         tick(6);
         outs(6'h00);
      end
      send(16'h103F | {4'h0, 6'($urandom), 6'h00});
      // overcurrent, short pulse first
      a = $urandom_range(0, 5);
      ocHigh[a] = 1'b1;
      tick(3);
      ocHigh[a] = 1'b0;
      tick(OCC + 6);
      outs(6'h00);
      ocLow[a] = 1'b1;
      underload[a] = 1'b1;
      tick(OCC + 8);
      outs(6'(1 << a));
      chkB(ocFlag, 1'b1, "oc flag");
      code(a, HBS_OC);
      tick(ULC + 6);
      code(a, HBS_OC);
      {ocLow, underload} = '0;
      host.poll(st, pre);
      chkB(st[13], 1'b1, "oc status");
      clearReq();
      outs(6'h00);
      chkB(ocFlag | ulFlag, 1'b0, "cleared");
      ocHigh[a] = 1'b1;
      clearReq();
      outs(6'(1 << a));
      ocHigh[a] = 1'b0;
      clearReq();
      // underload shares one timer
      a = $urandom_range(0, 2);
      b = a + 3;
      underload[a] = 1'b1;
      tick(10);
      underload[b] = 1'b1;
      tick(ULC - 2);
      outs(6'((1 << a) | (1 << b)));
      code(b, HBS_UL);
      chkB(ulFlag, 1'b1, "ul flag");
      underload = '0;
      clearReq();
      cmd[12] = 1'b0;
      send(cmd);
      underload[b] = 1'b1;
      tick(ULC + 8);
      outs(6'h00);
      chkB(ulFlag, 1'b1, "ul kept");
      underload = '0;
      clearReq();
      // thermal warning and shutdown
      host.poll(st, pre);
      chkB(pre, 1'b0, "pre bit");
      fork
         host.poll(st, pre);
         #400 thermWarn[a] = 1'b1;
      join
      chkB(st[15], 1'b0, "frozen");
      tick(6);
      chkB(twFlag, 1'b1, "warn");
      outs(6'h00);
      host.poll(st, pre);
      chkB(st[15], 1'b1, "fresh");
      thermShut[b] = 1'b1;
      tick(6);
      thermShut[b] = 1'b0;
      tick(2);
      outs(6'(1 << b));
      code(b, HBS_TSD);
      chkB(twFlag, 1'b1, "warn kept");
      thermWarn = '0;
      tick(6);
      chkB(twFlag, 1'b0, "warn clear");
      host.poll(st, pre);
      tick(8);
      chkB(pre, 1'b1, "pre tsd");
      chkB(tsdFlag, 1'b1, "tsd flag");
      clearReq();
      outs(6'h00);
      // enable pin clears latched status
      ocLow[a] = 1'b1;
      tick(OCC + 8);
      ocLow[a] = 1'b0;
      enablePin = 1'b0;
      tick(6);
      chkB(ocFlag, 1'b0, "en clear");
      chkV({4'h0, highSideOn, lowSideOn}, 16'h0000, "en off");
      enablePin = 1'b1;
      tick(6);
      chkB(ocFlag, 1'b0, "en stays");
      print_verdict();
   end
endmodule
`default_nettype wire
